// *** hdl/awss_pkg.sv ***
package awss_pkg;
   // sample count limits and converter range
   localparam logic [14:0] MIN_PTS   = 15'h0008;
   localparam logic [14:0] MAX_PTS   = 15'h3E80;
   localparam logic [15:0] DAC_MAX   = 16'h07FF;
   localparam logic [15:0] FLT_ONE   = 16'h4000;
   localparam logic [12:0] DAC_SCALE = 13'h07FF;
   localparam int          NAME_MAX  = 8;
   localparam int          NUM_BI    = 5;
   localparam int          NUM_USER  = 4;
   localparam int          CAT_LEN   = 10;
   localparam int          ESR_OPC   = 0;
   localparam logic [7:0]  OPC_CHAR  = 8'h31;
   // error numbers
   localparam logic [9:0]  ERR_NAME_LONG  = 10'h30F;
   localparam logic [9:0]  ERR_NO_WAVE    = 10'h311;
   localparam logic [9:0]  ERR_NAME_CHAR  = 10'h30C;
   localparam logic [9:0]  ERR_PT_COUNT   = 10'h30B;
   localparam logic [9:0]  ERR_DATA_RANGE = 10'h30A;
   // names, right aligned, zero padded on the left
   localparam logic [63:0] VOL_NAME = "VOLATILE";
   localparam logic [NUM_BI-1:0][63:0] BI_NAMES = {
      64'("CARDIAC"), 64'("EXP_FALL"), 64'("EXP_RISE"), 64'("NEG_RAMP"), 64'("SINC")};

   typedef enum logic [3:0] {
      OP_NOP        = 4'h0, OP_SELECT     = 4'h1, OP_ARB_START  = 4'h2,
      OP_SET_FUNC   = 4'h3, OP_DL_FLOAT   = 4'h4, OP_DL_INT     = 4'h5,
      OP_BYTE_ORDER = 4'h6, OP_TRIG_SRC   = 4'h7, OP_OPC        = 4'h8,
      OP_OPC_QUERY  = 4'h9, OP_CATALOG    = 4'hA, OP_SEL_QUERY  = 4'hB,
      OP_FUNC_QUERY = 4'hC, OP_TRIG_QUERY = 4'hD
   } awss_op_type;

   typedef enum logic [2:0] {
      F_SIN = 3'h0, F_SQU = 3'h1, F_TRI = 3'h2, F_RAMP = 3'h3,
      F_NOIS = 3'h4, F_DC = 3'h5, F_USER = 3'h6
   } awss_func_type;

   typedef enum logic [1:0] {
      T_IMM = 2'h0, T_EXT = 2'h1, T_BUS = 2'h2
   } awss_trig_type;

   typedef enum logic [1:0] {
      S_BUILTIN = 2'h0, S_VOL = 2'h1, S_USER = 2'h2
   } awss_kind_type;

   typedef enum logic [2:0] {
      M_NONE = 3'h0, M_AM = 3'h1, M_FM = 3'h2, M_FSK = 3'h3,
      M_BURST = 3'h4, M_SWEEP = 3'h5
   } awss_mod_type;

   typedef enum logic [2:0] {
      R_OPC = 3'h0, R_TRIG = 3'h1, R_FUNC = 3'h2, R_NAME = 3'h3,
      R_CAT = 3'h4, R_CAT_END = 3'h5
   } awss_rkind_type;

   typedef struct packed {
      awss_op_type op;
      logic [15:0] arg;
   } awss_cmd_type;

   typedef struct packed {
      awss_rkind_type kind;
      logic [63:0]    data;
   } awss_resp_type;
endpackage

// *** hdl/awss_core.sv ***
// Functional notes
// - opc query answers 1 after sweep ends
// - opc command sets status bit 0
// - trigger query returns imm, ext or bus
// - downloads hold 8 to 16000 points
// - float samples in -1..+1 stored volatile
// - integer samples -2047..+2047 stored volatile
// - -1/+1 scale linearly to peak codes
// - new download replaces volatile without error
// - select builtin, user or volatile waveform
// - selection alone never starts output
// - start keeps frequency, amplitude, offset settings
// - missing waveform gives 785, keeps selection
// - names: letter first, then letters/digits/underscore
// - names over eight chars give 783
// - name characters folded to upper case
// - selection query returns selected name
// - offset lamp when mean beyond two counts
// - function query returns function code
// - arb anywhere, noise only AM/FM modulating
// - volatile keyword only in full spelling
// - catalog lists builtins, volatile, user names
module awss_core import awss_pkg::*; (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic                       cmd_valid,
   input  wire awss_cmd_type               cmd,
   input  wire logic                       name_valid,
   input  wire logic [7:0]                 name_char,
   input  wire logic                       smp_valid,
   input  wire logic [15:0]                smp_data,
   input  wire logic                       smp_last,
   input  wire logic                       sweep_busy,
   input  wire logic                       esr_clear,
   input  wire logic [NUM_USER-1:0]        user_valid,
   input  wire logic [NUM_USER-1:0][63:0]  user_names,
   input  wire logic [NUM_USER-1:0]        user_offset,
   input  wire logic [NUM_BI-1:0]          bi_offset,
   input  wire awss_mod_type               mod_mode,
   input  wire awss_func_type              mod_shape,
   input  wire logic [13:0]                rd_addr,
   output awss_func_type                   func_q,
   output awss_trig_type                   trig_q,
   output awss_kind_type                   sel_kind_q,
   output logic [2:0]                      sel_idx_q,
   output logic [63:0]                     sel_name_q,
   output logic                            byte_swap_q,
   output logic                            vol_valid_q,
   output logic [14:0]                     vol_len_q,
   output logic                            offset_led_q,
   output logic                            combo_ok_q,
   output logic                            busy_q,
   output logic                            err_valid_q,
   output logic [9:0]                      err_code_q,
   output logic                            resp_valid_q,
   output awss_resp_type                   resp_q,
   output logic [7:0]                      esr_q,
   output logic [11:0]                     rd_data_q
);

   function automatic logic [7:0] upcase(input logic [7:0] c);
      upcase = (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
   endfunction

   function automatic logic [27:0] mag28(input logic [27:0] x);
      mag28 = x[27] ? 28'(-x) : x;
   endfunction

   function automatic logic [15:0] mag16(input logic [15:0] x);
      mag16 = x[15] ? 16'(-x) : x;
   endfunction

   logic [63:0]  name_q;
   logic [3:0]   name_len_q;
   logic         name_bad_q;
   logic         dl_active_q, dl_float_q, dl_bad_q, act_bank_q, vol_offs_q;
   logic [14:0]  dl_cnt_q;
   logic [27:0]  dl_sum_q;
   logic         cat_active_q;
   logic [3:0]   cat_idx_q;
   logic         opc_query_q, opc_cmd_q;
   logic [11:0]  mem [0:32767];

   // command acceptance, only while idle
   wire         cmd_take = cmd_valid && !busy_q;
   wire         do_op[16];
   for (genvar g = 0; g < 16; g++) begin : g_op
      assign do_op[g] = cmd_take && (cmd.op == awss_op_type'(g));
   end

   // name folding and character checks
   wire [7:0]  up_char  = upcase(name_char);
   wire        is_alpha = up_char >= 8'h41 && up_char <= 8'h5A;
   wire        is_digit = name_char >= 8'h30 && name_char <= 8'h39;
   wire        char_bad = (name_len_q == 4'h0) ? !is_alpha :
                          !(is_alpha || is_digit || name_char == 8'h5F);
   wire [63:0] name_base = do_op[OP_SELECT] ? 64'h0 : name_q;
   wire [3:0]  len_base  = do_op[OP_SELECT] ? 4'h0 : name_len_q;

   // name lookup against builtins and stored user waveforms
   logic       bi_hit, us_hit;
   logic [2:0] bi_idx, us_idx;
   always_comb begin
      bi_hit = 1'b0;
      bi_idx = 3'h0;
      us_hit = 1'b0;
      us_idx = 3'h0;
      for (int i = 0; i < NUM_BI; i++) begin
         if (name_q == BI_NAMES[i]) begin
            bi_hit = 1'b1;
            bi_idx = 3'(i);
         end
      end
      for (int i = 0; i < NUM_USER; i++) begin
         if (user_valid[i] && name_q == user_names[i]) begin
            us_hit = 1'b1;
            us_idx = 3'(i);
         end
      end
   end

   // exact full-length match only, so short forms fall through to missing
   wire vol_hit  = name_q == VOL_NAME;
   wire too_long = name_len_q > 4'(NAME_MAX);
   wire syn_bad  = name_bad_q || name_len_q == 4'h0;
   wire sel_ok   = !too_long && !syn_bad &&
                   (bi_hit || us_hit || (vol_hit && vol_valid_q));

   // sample assembly and conversion
   wire [15:0] smp_raw = byte_swap_q ? {smp_data[7:0], smp_data[15:8]} : smp_data;
   wire signed [28:0] flt_prod = $signed(smp_raw) * $signed(DAC_SCALE);
   wire [11:0] smp_code = dl_float_q ? flt_prod[25:14] : smp_raw[11:0];
   wire        smp_bad  = dl_float_q ? mag16(smp_raw) > FLT_ONE
                                     : mag16(smp_raw) > DAC_MAX;
   wire        smp_take = smp_valid && dl_active_q;
   wire        over     = dl_cnt_q >= MAX_PTS;
   wire [14:0] cnt_nx   = dl_cnt_q + 15'h0001;
   wire [27:0] sum_nx   = dl_sum_q + {{16{smp_code[11]}}, smp_code};
   wire        dl_end   = smp_take && smp_last;
   wire        cnt_ok   = cnt_nx >= MIN_PTS && cnt_nx <= MAX_PTS && !over;
   wire        data_ok  = !dl_bad_q && !smp_bad;
   wire        dl_ok    = dl_end && cnt_ok && data_ok;

   // catalog walk: entry present test and entry name
   wire [3:0]  cat_uidx = cat_idx_q - 4'h6;
   wire        cat_end  = cat_idx_q == 4'(CAT_LEN);
   wire        cat_here = cat_idx_q < 4'h5 ||
                          (cat_idx_q == 4'h5 && vol_valid_q) ||
                          (cat_idx_q > 4'h5 && !cat_end && user_valid[cat_uidx[1:0]]);
   wire [63:0] cat_name = cat_idx_q < 4'h5 ? BI_NAMES[cat_idx_q[2:0]] :
                          cat_idx_q == 4'h5 ? VOL_NAME : user_names[cat_uidx[1:0]];

   // query answers that come straight from a command
   wire        q_resp = do_op[OP_SEL_QUERY] || do_op[OP_FUNC_QUERY] ||
                        do_op[OP_TRIG_QUERY] || (cat_active_q && (cat_here || cat_end));
   wire        opc_fire = !sweep_busy && !dl_active_q;

   // name collection
   always_ff @(posedge core_clk) begin
      if (rst) begin
         name_q     <= 64'h0;
         name_len_q <= 4'h0;
         name_bad_q <= 1'b0;
      end else if (name_valid) begin
         name_q     <= {name_base[55:0], up_char};
         name_len_q <= (len_base > 4'(NAME_MAX)) ? len_base : len_base + 4'h1;
         name_bad_q <= (do_op[OP_SELECT] ? 1'b0 : name_bad_q) || char_bad;
      end else if (do_op[OP_SELECT]) begin
         name_q     <= 64'h0;
         name_len_q <= 4'h0;
         name_bad_q <= 1'b0;
      end
   end

   // function, trigger source and selection state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         func_q      <= F_SIN;
         trig_q      <= T_IMM;
         sel_kind_q  <= S_BUILTIN;
         sel_idx_q   <= 3'h0;
         sel_name_q  <= BI_NAMES[0];
         byte_swap_q <= 1'b0;
      end else begin
         if (do_op[OP_ARB_START]) func_q <= F_USER;
         if (do_op[OP_SET_FUNC] && cmd.arg[2:0] <= 3'(F_DC))
            func_q <= awss_func_type'(cmd.arg[2:0]);
         if (do_op[OP_TRIG_SRC] && cmd.arg[1:0] != 2'h3)
            trig_q <= awss_trig_type'(cmd.arg[1:0]);
         if (do_op[OP_BYTE_ORDER]) byte_swap_q <= cmd.arg[0];
         if (do_op[OP_SELECT] && sel_ok) begin
            sel_name_q <= name_q;
            if (bi_hit) begin
               sel_kind_q <= S_BUILTIN;
               sel_idx_q  <= bi_idx;
            end else if (us_hit) begin
               sel_kind_q <= S_USER;
               sel_idx_q  <= us_idx;
            end else begin
               sel_kind_q <= S_VOL;
               sel_idx_q  <= 3'h0;
            end
         end
      end
   end

   // download sequencing into the idle bank, swap only on a good finish
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dl_active_q <= 1'b0;
         dl_float_q  <= 1'b0;
         dl_bad_q    <= 1'b0;
         dl_cnt_q    <= 15'h0;
         dl_sum_q    <= 28'h0;
         act_bank_q  <= 1'b0;
         vol_valid_q <= 1'b0;
         vol_len_q   <= 15'h0;
         vol_offs_q  <= 1'b0;
      end else if (do_op[OP_DL_FLOAT] || do_op[OP_DL_INT]) begin
         dl_active_q <= 1'b1;
         dl_float_q  <= do_op[OP_DL_FLOAT];
         dl_bad_q    <= 1'b0;
         dl_cnt_q    <= 15'h0;
         dl_sum_q    <= 28'h0;
      end else if (smp_take) begin
         dl_bad_q <= dl_bad_q || smp_bad;
         dl_cnt_q <= over ? dl_cnt_q : cnt_nx;
         dl_sum_q <= sum_nx;
         if (dl_end) dl_active_q <= 1'b0;
         if (dl_ok) begin
            act_bank_q  <= !act_bank_q;
            vol_valid_q <= 1'b1;
            vol_len_q   <= cnt_nx;
            vol_offs_q  <= mag28(sum_nx) > 28'({cnt_nx, 1'b0});
         end
      end
   end

   // waveform storage, two banks of volatile memory
   always_ff @(posedge core_clk) begin
      if (smp_take && !over) mem[{!act_bank_q, dl_cnt_q[13:0]}] <= smp_code;
      rd_data_q <= mem[{act_bank_q, rd_addr}];
   end

   // errors, one-cycle strobe with held code
   always_ff @(posedge core_clk) begin
      if (rst) begin
         err_valid_q <= 1'b0;
         err_code_q  <= 10'h0;
      end else begin
         err_valid_q <= 1'b0;
         if (do_op[OP_SELECT] && !sel_ok) begin
            err_valid_q <= 1'b1;
            err_code_q  <= too_long ? ERR_NAME_LONG :
                           syn_bad ? ERR_NAME_CHAR : ERR_NO_WAVE;
         end else if (dl_end && !dl_ok) begin
            err_valid_q <= 1'b1;
            err_code_q  <= cnt_ok ? ERR_DATA_RANGE : ERR_PT_COUNT;
         end
      end
   end

   // operation complete tracking and event status
   always_ff @(posedge core_clk) begin
      if (rst) begin
         opc_query_q <= 1'b0;
         opc_cmd_q   <= 1'b0;
         esr_q       <= 8'h0;
      end else begin
         if (do_op[OP_OPC_QUERY]) opc_query_q <= 1'b1;
         else if (opc_query_q && opc_fire && !q_resp) opc_query_q <= 1'b0;
         if (do_op[OP_OPC]) opc_cmd_q <= 1'b1;
         else if (opc_cmd_q && opc_fire) opc_cmd_q <= 1'b0;
         // a set in the clearing cycle wins
         if (opc_cmd_q && opc_fire) esr_q[ESR_OPC] <= 1'b1;
         else if (esr_clear) esr_q[ESR_OPC] <= 1'b0;
      end
   end

   // responses and catalog walk
   always_ff @(posedge core_clk) begin
      if (rst) begin
         resp_valid_q <= 1'b0;
         resp_q       <= '0;
         cat_active_q <= 1'b0;
         cat_idx_q    <= 4'h0;
      end else begin
         resp_valid_q <= q_resp || (opc_query_q && opc_fire);
         if (do_op[OP_CATALOG]) begin
            cat_active_q <= 1'b1;
            cat_idx_q    <= 4'h0;
         end else if (cat_active_q) begin
            cat_idx_q <= cat_idx_q + 4'h1;
            if (cat_end) cat_active_q <= 1'b0;
         end
         if (cat_active_q && cat_end) resp_q <= '{R_CAT_END, 64'h0};
         else if (cat_active_q) resp_q <= '{R_CAT, cat_name};
         else if (do_op[OP_SEL_QUERY]) resp_q <= '{R_NAME, sel_name_q};
         else if (do_op[OP_FUNC_QUERY]) resp_q <= '{R_FUNC, 64'(func_q)};
         else if (do_op[OP_TRIG_QUERY]) resp_q <= '{R_TRIG, 64'(trig_q)};
         else if (opc_query_q && opc_fire) resp_q <= '{R_OPC, 64'(OPC_CHAR)};
      end
   end

   // offset lamp, shape/modulation legality, busy
   wire offs_sel = sel_kind_q == S_VOL ? vol_offs_q :
                   sel_kind_q == S_USER ? user_offset[sel_idx_q[1:0]] : bi_offset[sel_idx_q];
   wire am_fm    = mod_mode == M_AM || mod_mode == M_FM;
   wire combo    = !(mod_mode != M_NONE && func_q == F_NOIS) &&
                   !(mod_shape == F_NOIS && mod_mode != M_NONE && !am_fm);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         offset_led_q <= 1'b0;
         combo_ok_q   <= 1'b1;
         busy_q       <= 1'b0;
      end else begin
         offset_led_q <= func_q == F_USER && offs_sel;
         combo_ok_q   <= combo;
         busy_q       <= (dl_active_q && !dl_end) || do_op[OP_DL_FLOAT] || do_op[OP_DL_INT]
                         || (cat_active_q && !cat_end) || do_op[OP_CATALOG];
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   a_opc_reply: assert property (resp_valid_q && resp_q.kind == R_OPC |-> $past(!sweep_busy))
      else $error("opc reply during sweep");
   a_opc_bit: assert property ($rose(esr_q[ESR_OPC]) |-> $past(opc_cmd_q && !sweep_busy))
      else $error("opc bit set without completion");
   a_trig_reply: assert property (do_op[OP_TRIG_QUERY] |=> resp_valid_q && resp_q.data[1:0] == trig_q)
      else $error("trigger query reply wrong");
   a_len_range: assert property ($changed(vol_len_q) |-> vol_len_q >= MIN_PTS && vol_len_q <= MAX_PTS)
      else $error("volatile length out of range");
   a_sel_nostart: assert property (do_op[OP_SELECT] && !do_op[OP_ARB_START] |=> $stable(func_q))
      else $error("selection changed function");
   a_start_user: assert property (do_op[OP_ARB_START] |=> func_q == F_USER)
      else $error("start did not select user function");
   a_missing_keep: assert property (do_op[OP_SELECT] && !sel_ok && !too_long && !syn_bad |=> err_valid_q && err_code_q == ERR_NO_WAVE && $stable(sel_name_q))
      else $error("missing waveform not reported");
   a_long_name: assert property (do_op[OP_SELECT] && too_long |=> err_valid_q && err_code_q == ERR_NAME_LONG)
      else $error("long name not reported");
   a_offs_lamp: assert property (offset_led_q |-> $past(func_q) == F_USER)
      else $error("offset lamp without arb output");
   a_cat_end: assert property (do_op[OP_CATALOG] |-> ##[2:12] resp_valid_q && resp_q.kind == R_CAT_END)
      else $error("catalog not terminated");
   a_bad_count: assert property (dl_end && !cnt_ok |=> $stable(act_bank_q) && err_code_q == ERR_PT_COUNT)
      else $error("bad count not rejected");

endmodule // awss_core

// *** tb/awss_host.sv ***
module awss_host import awss_pkg::*; (
   input  wire logic    core_clk,
   input  wire logic    busy_q,
   output awss_cmd_type cmd,
   output logic         cmd_valid,
   output logic         name_valid,
   output logic [7:0]   name_char,
   output logic         smp_valid,
   output logic [15:0]  smp_data,
   output logic         smp_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic swap_q;

   // idle levels from time zero
   initial begin
      {cmd_valid, name_valid, smp_valid, smp_last, swap_q} = '0;
      cmd = '0;
      name_char = 8'h00;
      smp_data = 16'h0000;
   end

   // one command, issued once the block is idle or after 40000 busy cycles
   task automatic send(awss_op_type op, logic [15:0] arg);
      int n;
      n = 0;
      @(negedge core_clk);
      while (busy_q !== 1'b0 && n < 40000) begin
         @(negedge core_clk);
         n++;
      end
      cmd_valid = 1'b1;
      cmd.op = op;
      cmd.arg = arg;
      if (op == OP_BYTE_ORDER) swap_q = arg[0];
      @(negedge core_clk);
      cmd_valid = 1'b0;
      cmd.arg = ~arg;
   endtask

   // name characters, one per cycle
   task automatic name(string s);
      for (int i = 0; i < s.len(); i++) begin
         @(negedge core_clk);
         name_valid = 1'b1;
         name_char = s[i];
      end
      @(negedge core_clk);
      name_valid = 1'b0;
      name_char = ~name_char;
   endtask

   // download: command, then samples in the chosen byte order
   task automatic dl(awss_op_type op, logic [15:0] q[$]);
      send(op, 16'h0000);
      foreach (q[i]) begin
         smp_valid = 1'b1;
         smp_data = swap_q ? {q[i][7:0], q[i][15:8]} : q[i];
         smp_last = (i == q.size() - 1);
         @(negedge core_clk);
      end
      smp_valid = 1'b0;
      smp_last = 1'b0;
      smp_data = ~smp_data;
   endtask
endmodule // awss_host

// *** tb/arb_waveform_store_select_tb_top.sv ***
module arb_waveform_store_select_tb_top import awss_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst = 1'b1, sweep_busy = 1'b0, esr_clear = 1'b0;
   logic cmd_valid, name_valid, smp_valid, smp_last, busy_q, byte_swap_q, vol_valid_q;
   logic offset_led_q, combo_ok_q, err_valid_q, resp_valid_q;
   logic [7:0] name_char, esr_q;
   logic [15:0] smp_data;
   logic [NUM_USER-1:0] user_valid = 4'h4, user_offset = 4'h0;
   logic [NUM_USER-1:0][63:0] user_names = {64'h0, 64'("ARB_1"), 128'h0};
   logic [NUM_BI-1:0] bi_offset = 5'h02;
   awss_mod_type mod_mode = M_NONE;
   awss_func_type mod_shape = F_SIN, func_q;
   logic [13:0] rd_addr = 14'h0000;
   awss_cmd_type cmd;
   awss_trig_type trig_q;
   awss_kind_type sel_kind_q;
   logic [2:0] sel_idx_q;
   logic [63:0] sel_name_q;
   logic [14:0] vol_len_q;
   logic [9:0] err_code_q;
   logic [11:0] rd_data_q;
   awss_resp_type resp_q, rq[$];
   logic [9:0] eq[$];
   logic [15:0] q[$];
   int checked = 0, miscompares = 0;

   always #5 core_clk = ~core_clk;

   awss_host i_host (.core_clk(core_clk), .busy_q(busy_q), .cmd(cmd), .cmd_valid(cmd_valid),
      .name_valid(name_valid), .name_char(name_char), .smp_valid(smp_valid),
      .smp_data(smp_data), .smp_last(smp_last));

   awss_core i_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
      .name_valid(name_valid), .name_char(name_char), .smp_valid(smp_valid),
      .smp_data(smp_data), .smp_last(smp_last), .sweep_busy(sweep_busy),
      .esr_clear(esr_clear), .user_valid(user_valid), .user_names(user_names),
      .user_offset(user_offset), .bi_offset(bi_offset), .mod_mode(mod_mode),
      .mod_shape(mod_shape), .rd_addr(rd_addr), .func_q(func_q), .trig_q(trig_q),
      .sel_kind_q(sel_kind_q), .sel_idx_q(sel_idx_q), .sel_name_q(sel_name_q),
      .byte_swap_q(byte_swap_q), .vol_valid_q(vol_valid_q), .vol_len_q(vol_len_q),
      .offset_led_q(offset_led_q), .combo_ok_q(combo_ok_q), .busy_q(busy_q),
      .err_valid_q(err_valid_q), .err_code_q(err_code_q), .resp_valid_q(resp_valid_q),
      .resp_q(resp_q), .esr_q(esr_q), .rd_data_q(rd_data_q));

   // collect one-cycle reply and error pulses
   always @(negedge core_clk) begin
      if (resp_valid_q === 1'b1) rq.push_back(resp_q);
      if (err_valid_q === 1'b1) eq.push_back(err_code_q);
   end

   task automatic settle(int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic chk_val(logic [63:0] got, logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_err(logic [9:0] exp);
      logic [9:0] g;
      g = 'x;
      if (eq.size() > 0) g = eq.pop_front();
      chk_val(g, exp);
   endtask

   task automatic chk_resp(awss_rkind_type k, logic [63:0] d, bit any_d = 0);
      awss_resp_type r;
      r = 'x;
      if (rq.size() > 0) r = rq.pop_front();
      chk_val(r.kind, k);
      if (!any_d) chk_val(r.data, d);
   endtask

   // playback read, data one cycle after the address
   task automatic rd(logic [13:0] a, logic [11:0] exp);
      @(negedge core_clk);
      rd_addr = a;
      @(negedge core_clk);
      chk_val(rd_data_q, exp);
   endtask

   task automatic sel(string s);
      i_host.name(s);
      i_host.send(OP_SELECT, 16'h0000);
      settle(3);
   endtask

   task automatic dl(awss_op_type op);
      i_host.dl(op, q);
      settle(2);
   endtask

   task automatic combo(awss_mod_type m, awss_func_type s, logic exp);
      mod_mode = m;
      mod_shape = s;
      settle(3);
      chk_val(combo_ok_q, exp);
   endtask

   task automatic test_done;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // watchdog, well beyond the expected run of about 32k cycles
   initial begin
      #700000;
      miscompares++;
      test_done;
   end

   // main sequence
   initial begin
      settle(2);
      rst = 1'b0;
      chk_val(func_q, F_SIN);
      chk_val(sel_name_q, 64'("SINC"));
      for (int i = 0; i < 3; i++) begin
         i_host.send(OP_TRIG_SRC, 16'(i));
         i_host.send(OP_TRIG_QUERY, 16'h0000);
         settle(2);
         chk_resp(R_TRIG, 64'(i));
      end
      for (int i = 0; i < 6; i++) begin
         i_host.send(OP_SET_FUNC, 16'(i));
         i_host.send(OP_FUNC_QUERY, 16'h0000);
         settle(2);
         chk_resp(R_FUNC, 64'(i));
      end
      i_host.send(OP_SET_FUNC, 16'h0000);
      // integer codes, full scale ends, then too short and out of range
      q = '{16'h07FF, 16'h0600, 16'h0400, 16'h0200, 16'h0000, 16'hFE00, 16'hFA00, 16'hF801};
      dl(OP_DL_INT);
      chk_val(eq.size(), 0);
      chk_val(vol_len_q, 15'h0008);
      rd(14'h0000, 12'h7FF);
      rd(14'h0007, 12'h801);
      void'(q.pop_back());
      dl(OP_DL_INT);
      chk_err(10'h30B);
      chk_val(vol_len_q, 15'h0008);
      rd(14'h0000, 12'h7FF);
      q.push_back(16'h0800);
      dl(OP_DL_INT);
      chk_err(10'h30A);
      // normalized values with swapped byte order
      i_host.send(OP_BYTE_ORDER, 16'h0001);
      settle(2);
      chk_val(byte_swap_q, 1'b1);
      q = '{16'h4000, 16'h3000, 16'h2000, 16'h1000, 16'h0000, 16'hF000, 16'hE000, 16'hD000, 16'hC000};
      dl(OP_DL_FLOAT);
      chk_val(eq.size(), 0);
      chk_val(vol_len_q, 15'h0009);
      rd(14'h0000, 12'h7FF);
      rd(14'h0008, 12'h801);
      q[0] = 16'h4001;
      dl(OP_DL_FLOAT);
      chk_err(10'h30A);
      i_host.send(OP_BYTE_ORDER, 16'h0000);
      // selection by name
      sel("volatile");
      chk_val(sel_kind_q, S_VOL);
      chk_val(func_q, F_SIN);
      i_host.send(OP_SEL_QUERY, 16'h0000);
      settle(2);
      chk_resp(R_NAME, VOL_NAME);
      sel("VOLAT");
      chk_err(10'h311);
      sel("arb_1");
      chk_val(sel_name_q, 64'("ARB_1"));
      sel("ARB_2");
      chk_err(10'h311);
      chk_val(sel_kind_q, S_USER);
      sel("ARB_LONG9");
      chk_err(10'h30F);
      sel("9ABC");
      chk_err(10'h30C);
      sel("neg_ramp");
      chk_val(sel_name_q, 64'("NEG_RAMP"));
      i_host.send(OP_ARB_START, 16'h0000);
      settle(3);
      chk_val(func_q, F_USER);
      chk_val(trig_q, T_BUS);
      chk_val(offset_led_q, 1'b1);
      // volatile mean exactly two counts, then just above
      sel("VOLATILE");
      q = '{8{16'h0002}};
      dl(OP_DL_INT);
      settle(2);
      chk_val(offset_led_q, 1'b0);
      q[0] = 16'h0003;
      dl(OP_DL_INT);
      settle(2);
      chk_val(offset_led_q, 1'b1);
      // catalog walk
      i_host.send(OP_CATALOG, 16'h0000);
      settle(16);
      for (int i = 0; i < NUM_BI; i++) chk_resp(R_CAT, BI_NAMES[i]);
      chk_resp(R_CAT, VOL_NAME);
      chk_resp(R_CAT, 64'("ARB_1"));
      chk_resp(R_CAT_END, 64'h0, 1);
      // completion waits for the sweep
      sweep_busy = 1'b1;
      i_host.send(OP_OPC_QUERY, 16'h0000);
      i_host.send(OP_OPC, 16'h0000);
      settle(6);
      chk_val(rq.size(), 0);
      chk_val(esr_q, 8'h00);
      sweep_busy = 1'b0;
      settle(4);
      chk_resp(R_OPC, 64'(OPC_CHAR));
      chk_val(esr_q, 8'h01);
      esr_clear = 1'b1;
      settle(1);
      esr_clear = 1'b0;
      settle(2);
      chk_val(esr_q, 8'h00);
      // modulation combinations
      combo(M_AM, F_NOIS, 1'b1);
      combo(M_SWEEP, F_NOIS, 1'b0);
      combo(M_BURST, F_USER, 1'b1);
      i_host.send(OP_SET_FUNC, 16'h0004);
      combo(M_FM, F_SIN, 1'b0);
      // largest count accepted, one more refused
      q = {};
      repeat (16000) q.push_back(16'h0000);
      dl(OP_DL_INT);
      chk_val(vol_len_q, 15'h3E80);
      q.push_back(16'h0000);
      dl(OP_DL_INT);
      chk_err(10'h30B);
      chk_val(vol_len_q, 15'h3E80);
      test_done;
   end
endmodule // arb_waveform_store_select_tb_top
